// File: hw/fpcd_decoder.sv
// Command decoder for drive positioning and housekeeping commands
//
// Overview of operation
// - Select line low reaches main status, high reaches the data register.
// - Recalibrate is two bytes, code 07, and drives the head to track zero.
// - Seek is three bytes; third byte is the target cylinder to reach.
// - Sense interrupt status is one byte, then returns end-of-positioning status.
// - Present cylinder returned is the head position when the seek or recalibrate ends.
// - Sense drive status takes a select byte and returns drive condition status.
// - Step interval 1 to 16 ms for all drives, coded F=1 ms, E=2 ms.
// - Head settle time 2 to 254 ms in 2 ms steps after loading.
// - Head release delay 16 to 240 ms in 16 ms steps after transfer.
// - No-DMA flag from specify makes execution use programmed access.
// - Two drive select bits choose one of four drives as a binary number.
// - Head select bit picks head 0 or 1 and sets the head output.
// - Density bit low selects FM, high selects MFM recording.
// - Multi-side bit continues from side 0 to sector 1 on side 1.
// - Cylinder identifiers are values 0 through 255.
// - Size code 00 makes the short sector length the byte count.
// - Transfer stops after the sector equal to last sector number.
// - Format sizes gap three from the gap length parameter.
// - Scan stride 1 compares contiguous sectors, stride 2 alternate ones.
// - Command status bytes are readable only in the result phase.
// - Skip bit set skips sectors with a deleted data mark.
`timescale 1ns/1ns
module fpcd_decoder
  import fpcd_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reg_select_line,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic int_req,
  output logic no_dma_flag,
  input wire fpcd_drive_type [3:0] drive_in,
  output logic [3:0] drive_sel,
  output logic head_pick,
  output logic head_load,
  output logic step_pulse,
  output logic step_dir,
  output logic xfer_start,
  output fpcd_xfer_type xfer,
  input wire logic xfer_done,
  input wire fpcd_result_type xfer_result
);

  if (MS_CYCLES_P < 2) begin : g_check
    $error("MS_CYCLES_P must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  fpcd_phase_type phase;
  fpcd_phase_type next_phase;
  fpcd_head_type head_state;
  fpcd_head_type next_head_state;
  logic [7:0] cmd_buf [CMD_BYTES];
  logic [7:0] next_cmd_buf [CMD_BYTES];
  logic [3:0] cmd_idx;
  logic [3:0] next_cmd_idx;
  logic [3:0] cmd_len;
  logic [3:0] next_cmd_len;
  logic [7:0] res_buf [RES_BYTES];
  logic [7:0] next_res_buf [RES_BYTES];
  logic [2:0] res_idx;
  logic [2:0] next_res_idx;
  logic [2:0] res_len;
  logic [2:0] next_res_len;
  logic [3:0] step_interval;
  logic [3:0] next_step_interval;
  logic [3:0] head_release_delay;
  logic [3:0] next_head_release_delay;
  logic [6:0] head_settle_time;
  logic [6:0] next_head_settle_time;
  logic next_no_dma_flag;
  logic seek_active;
  logic next_seek_active;
  logic seek_recal;
  logic next_seek_recal;
  logic [1:0] seek_drive;
  logic [1:0] next_seek_drive;
  logic [7:0] target_cylinder;
  logic [7:0] next_target_cylinder;
  logic [7:0] seek_steps;
  logic [7:0] next_seek_steps;
  logic [7:0] present_cylinder [4];
  logic [7:0] next_present_cylinder [4];
  logic next_int_req;
  logic [7:0] int_st0;
  logic [7:0] next_int_st0;
  logic [7:0] int_pcn;
  logic [7:0] next_int_pcn;
  logic [1:0] drive_now;
  logic [1:0] next_drive_now;
  logic next_head_pick;
  logic next_step_pulse;
  logic next_step_dir;
  logic next_xfer_start;
  fpcd_xfer_type next_xfer;
  logic [7:0] next_host_rdata;
  logic step_go;
  logic [7:0] step_ms;
  logic step_done;
  logic head_go;
  logic [7:0] head_ms;
  logic head_done;

  function automatic logic [3:0] cmd_length(input logic [4:0] op);
    case (op)
      OP_SPECIFY, OP_SEEK: cmd_length = LEN_THREE;
      OP_SENSE_DRV, OP_RECAL, OP_READ_ID: cmd_length = LEN_TWO;
      OP_FORMAT: cmd_length = LEN_FORMAT;
      OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL, OP_READ_TRACK,
      OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: cmd_length = LEN_DATA;
      default: cmd_length = LEN_ONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timers

  fpcd_ms_timer #(.MS_CYCLES_P(MS_CYCLES_P)) u_step_timer (
    .clock(clock),
    .srst(srst),
    .start(step_go),
    .ms_count(step_ms),
    .busy(),
    .done(step_done)
  );

  fpcd_ms_timer #(.MS_CYCLES_P(MS_CYCLES_P)) u_head_timer (
    .clock(clock),
    .srst(srst),
    .start(head_go),
    .ms_count(head_ms),
    .busy(),
    .done(head_done)
  );

  for (genvar g = 0; g < 4; g++) begin : g_drive
    assign drive_sel[g] = (drive_now == 2'(g));
  end

  assign head_load = (head_state != HD_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] op_byte;
    logic [7:0] sel_byte;
    logic [3:0] len;
    logic [7:0] msr;
    logic kicked;
    logic [55:0] res_flat;
    op_byte = 8'h00;
    sel_byte = 8'h00;
    len = cmd_len;
    msr = 8'h00;
    kicked = 1'b0;
    res_flat = xfer_result;
    next_phase = phase;
    next_head_state = head_state;
    next_cmd_buf = cmd_buf;
    next_cmd_idx = cmd_idx;
    next_cmd_len = cmd_len;
    next_res_buf = res_buf;
    next_res_idx = res_idx;
    next_res_len = res_len;
    next_step_interval = step_interval;
    next_head_release_delay = head_release_delay;
    next_head_settle_time = head_settle_time;
    next_no_dma_flag = no_dma_flag;
    next_seek_active = seek_active;
    next_seek_recal = seek_recal;
    next_seek_drive = seek_drive;
    next_target_cylinder = target_cylinder;
    next_seek_steps = seek_steps;
    next_present_cylinder = present_cylinder;
    next_int_req = int_req;
    next_int_st0 = int_st0;
    next_int_pcn = int_pcn;
    next_drive_now = drive_now;
    next_head_pick = head_pick;
    next_step_pulse = 1'b0;
    next_step_dir = step_dir;
    next_xfer_start = 1'b0;
    next_xfer = xfer;
    step_go = 1'b0;
    step_ms = {3'h0, 5'(STEP_MS_BASE - {1'b0, step_interval})};
    head_go = 1'b0;
    head_ms = 8'(head_settle_time * SETTLE_MS_UNIT);

    // Head load and release
    case (head_state)
      HD_SETTLE: begin
        if (head_done) begin
          next_head_state = HD_ON;
          next_xfer_start = 1'b1;
        end
      end
      HD_RELEASE: begin
        if (head_done) begin
          next_head_state = HD_OFF;
        end
      end
      default: begin
      end
    endcase

    // Command phase
    if (host_wr && reg_select_line && phase == PH_CMD) begin
      next_cmd_buf[cmd_idx] = host_wdata;
      if (cmd_idx == 4'h0) begin
        len = cmd_length(host_wdata[4:0]);
      end
      next_cmd_len = len;
      next_cmd_idx = cmd_idx + 4'h1;
      if (cmd_idx == len - 4'h1) begin
        next_cmd_idx = 4'h0;
        op_byte = next_cmd_buf[0];
        sel_byte = next_cmd_buf[1];
        if (len > LEN_ONE) begin
          next_drive_now = sel_byte[1:0];
          next_head_pick = sel_byte[BIT_HEAD];
        end
        case (op_byte[4:0])
          OP_SPECIFY: begin
            next_step_interval = sel_byte[7:4];
            next_head_release_delay = sel_byte[3:0];
            next_head_settle_time = next_cmd_buf[2][7:1];
            next_no_dma_flag = next_cmd_buf[2][BIT_NO_DMA];
          end
          OP_SENSE_DRV: begin
            next_res_buf[0] = {drive_in[sel_byte[1:0]], sel_byte[BIT_HEAD],
                               sel_byte[1:0]};
            next_res_len = RES_ONE;
            next_res_idx = 3'h0;
            next_phase = PH_RESULT;
          end
          OP_SENSE_INT: begin
            next_res_idx = 3'h0;
            next_phase = PH_RESULT;
            if (int_req) begin
              next_res_buf[0] = int_st0;
              next_res_buf[1] = int_pcn;
              next_res_len = RES_TWO;
              next_int_req = 1'b0;
            end else begin
              next_res_buf[0] = ST0_INVALID;
              next_res_len = RES_ONE;
            end
          end
          OP_RECAL, OP_SEEK: begin
            kicked = 1'b1;
            next_seek_active = 1'b1;
            next_seek_recal = (op_byte[4:0] == OP_RECAL);
            next_seek_drive = sel_byte[1:0];
            next_target_cylinder = (op_byte[4:0] == OP_RECAL) ?
                                   CYL_RST : next_cmd_buf[2];
            next_seek_steps = 8'h00;
            step_go = 1'b1;
          end
          OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL, OP_READ_TRACK,
          OP_READ_ID, OP_FORMAT, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: begin
            next_xfer.op = op_byte[4:0];
            next_xfer.multi_side = op_byte[BIT_MULTI];
            next_xfer.double_density = op_byte[BIT_DENS];
            next_xfer.skip_deleted = op_byte[BIT_SKIP];
            next_xfer.head_pick = sel_byte[BIT_HEAD];
            next_xfer.drive = sel_byte[1:0];
            if (op_byte[4:0] == OP_FORMAT) begin
              next_xfer.size_code = next_cmd_buf[2];
              next_xfer.sectors_per_cylinder = next_cmd_buf[3];
              next_xfer.gap_three_length = next_cmd_buf[4];
              next_xfer.fill_byte = next_cmd_buf[5];
            end else begin
              next_xfer.cyl = next_cmd_buf[2];
              next_xfer.head_id = next_cmd_buf[3];
              next_xfer.sector = next_cmd_buf[4];
              next_xfer.size_code = next_cmd_buf[5];
              next_xfer.last_sector_number = next_cmd_buf[6];
              next_xfer.gap_three_length = next_cmd_buf[7];
              next_xfer.short_sector_length = next_cmd_buf[8];
              next_xfer.scan_stride = next_cmd_buf[8];
            end
            next_xfer.xfer_len = (next_xfer.size_code == 8'h00) ?
                                 {8'h00, next_xfer.short_sector_length} :
                                 SECTOR_BASE_LEN << next_xfer.size_code[2:0];
            next_phase = PH_EXEC;
            if (head_state == HD_ON || head_state == HD_RELEASE) begin
              next_head_state = HD_ON;
              next_xfer_start = 1'b1;
            end else begin
              next_head_state = HD_SETTLE;
              head_go = 1'b1;
            end
          end
          default: begin
            next_res_buf[0] = ST0_INVALID;
            next_res_len = RES_ONE;
            next_res_idx = 3'h0;
            next_phase = PH_RESULT;
          end
        endcase
      end
    end

    // Execution end of data commands
    if (phase == PH_EXEC && xfer_done) begin
      for (int i = 0; i < RES_BYTES; i++) begin
        next_res_buf[i] = res_flat[55 - 8 * i -: 8];
      end
      next_res_len = RES_DATA;
      next_res_idx = 3'h0;
      next_phase = PH_RESULT;
      next_head_state = HD_RELEASE;
      head_go = 1'b1;
      head_ms = 8'(head_release_delay * RELEASE_MS_UNIT);
    end

    // Result phase reads
    if (host_rd && reg_select_line && phase == PH_RESULT) begin
      if (res_idx == res_len - 3'h1) begin
        next_res_idx = 3'h0;
        next_phase = PH_CMD;
      end else begin
        next_res_idx = res_idx + 3'h1;
      end
    end

    // Stepping engine
    if (seek_active && step_done && !kicked) begin
      if (seek_recal ? drive_in[seek_drive].track_zero :
          present_cylinder[seek_drive] == target_cylinder) begin
        next_seek_active = 1'b0;
        if (seek_recal) begin
          next_present_cylinder[seek_drive] = CYL_RST;
        end
        next_int_req = 1'b1;
        next_int_st0 = ST0_SEEK_END | {6'h00, seek_drive};
        next_int_pcn = next_present_cylinder[seek_drive];
      end else if (seek_recal && seek_steps == RECAL_MAX_STEPS) begin
        next_seek_active = 1'b0;
        next_int_req = 1'b1;
        next_int_st0 = ST0_EQUIP_FAIL | {6'h00, seek_drive};
        next_int_pcn = present_cylinder[seek_drive];
      end else begin
        next_step_pulse = 1'b1;
        next_seek_steps = seek_steps + 8'h01;
        step_go = 1'b1;
        if (!seek_recal && target_cylinder > present_cylinder[seek_drive]) begin
          next_step_dir = 1'b1;
          next_present_cylinder[seek_drive] = present_cylinder[seek_drive] + 8'h01;
        end else begin
          next_step_dir = 1'b0;
          if (present_cylinder[seek_drive] != CYL_RST) begin
            next_present_cylinder[seek_drive] = present_cylinder[seek_drive] - 8'h01;
          end
        end
      end
    end

    // Host read data
    msr[MSR_RQM] = (phase != PH_EXEC);
    msr[MSR_DIO] = (phase == PH_RESULT);
    msr[MSR_EXM] = (phase == PH_EXEC) && no_dma_flag;
    msr[MSR_BUSY] = (phase != PH_CMD) || (cmd_idx != 4'h0);
    if (seek_active) begin
      msr[seek_drive] = 1'b1;
    end
    if (!reg_select_line) begin
      next_host_rdata = msr;
    end else if (phase == PH_RESULT) begin
      next_host_rdata = res_buf[res_idx];
    end else begin
      next_host_rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock) begin
    if (srst) begin
      phase <= PH_CMD;
      head_state <= HD_OFF;
      cmd_idx <= 4'h0;
      cmd_len <= LEN_ONE;
      res_idx <= 3'h0;
      res_len <= RES_ONE;
      step_interval <= STEP_INTERVAL_RST;
      head_release_delay <= RELEASE_DELAY_RST;
      head_settle_time <= SETTLE_TIME_RST;
      no_dma_flag <= NO_DMA_RST;
      seek_active <= 1'b0;
      seek_recal <= 1'b0;
      seek_drive <= 2'h0;
      target_cylinder <= CYL_RST;
      seek_steps <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        present_cylinder[i] <= CYL_RST;
      end
      int_req <= 1'b0;
      int_st0 <= 8'h00;
      int_pcn <= CYL_RST;
      drive_now <= 2'h0;
      head_pick <= 1'b0;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
      xfer_start <= 1'b0;
      xfer <= '0;
      host_rdata <= 8'h00;
    end else begin
      phase <= next_phase;
      head_state <= next_head_state;
      cmd_idx <= next_cmd_idx;
      cmd_len <= next_cmd_len;
      res_idx <= next_res_idx;
      res_len <= next_res_len;
      step_interval <= next_step_interval;
      head_release_delay <= next_head_release_delay;
      head_settle_time <= next_head_settle_time;
      no_dma_flag <= next_no_dma_flag;
      seek_active <= next_seek_active;
      seek_recal <= next_seek_recal;
      seek_drive <= next_seek_drive;
      target_cylinder <= next_target_cylinder;
      seek_steps <= next_seek_steps;
      present_cylinder <= next_present_cylinder;
      int_req <= next_int_req;
      int_st0 <= next_int_st0;
      int_pcn <= next_int_pcn;
      drive_now <= next_drive_now;
      head_pick <= next_head_pick;
      step_pulse <= next_step_pulse;
      step_dir <= next_step_dir;
      xfer_start <= next_xfer_start;
      xfer <= next_xfer;
      host_rdata <= next_host_rdata;
    end
  end

  always_ff @(posedge clock) begin
    cmd_buf <= next_cmd_buf;
    res_buf <= next_res_buf;
  end

endmodule

// File: hw/fpcd_ms_timer.sv
// Millisecond interval timer driven by a cycle prescaler
`timescale 1ns/1ns
module fpcd_ms_timer
  import fpcd_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic [7:0] ms_count,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2(MS_CYCLES_P);
  localparam logic [CW-1:0] CYC_LAST = CW'(MS_CYCLES_P - 1);

  if (MS_CYCLES_P < 2) begin : g_check
    $error("MS_CYCLES_P must be at least 2");
  end

  logic [CW-1:0] cyc;
  logic [CW-1:0] next_cyc;
  logic [7:0] ms;
  logic [7:0] next_ms;
  logic next_busy;
  assign done = busy && (cyc == CYC_LAST) && (ms == 8'h01);

  always_comb begin
    next_cyc = cyc;
    next_ms = ms;
    next_busy = busy;
    if (start) begin
      next_busy = 1'b1;
      next_cyc = '0;
      next_ms = (ms_count == 8'h00) ? 8'h01 : ms_count;
    end else if (busy) begin
      if (cyc == CYC_LAST) begin
        next_cyc = '0;
        if (ms == 8'h01) begin
          next_busy = 1'b0;
        end else begin
          next_ms = ms - 8'h01;
        end
      end else begin
        next_cyc = cyc + CW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cyc <= '0;
      ms <= 8'h00;
      busy <= 1'b0;
    end else begin
      cyc <= next_cyc;
      ms <= next_ms;
      busy <= next_busy;
    end
  end

endmodule

// File: hw/fpcd_pkg.sv
// Shared constants and types of the floppy positioning command decoder
package fpcd_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int MS_TIME_US = 1000;
  localparam int MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US;

  // Command codes, low five bits of the first command byte
  localparam logic [4:0] OP_READ = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0c;
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [4:0] OP_READ_TRACK = 5'h02;
  localparam logic [4:0] OP_READ_ID = 5'h0a;
  localparam logic [4:0] OP_FORMAT = 5'h0d;
  localparam logic [4:0] OP_SCAN_EQ = 5'h11;
  localparam logic [4:0] OP_SCAN_LE = 5'h19;
  localparam logic [4:0] OP_SCAN_HE = 5'h1d;
  localparam logic [4:0] OP_RECAL = 5'h07;
  localparam logic [4:0] OP_SENSE_INT = 5'h08;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV = 5'h04;
  localparam logic [4:0] OP_SEEK = 5'h0f;

  // Command byte counts
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_THREE = 4'h3;
  localparam logic [3:0] LEN_FORMAT = 4'h6;
  localparam logic [3:0] LEN_DATA = 4'h9;
  localparam int CMD_BYTES = 9;

  // Result byte counts
  localparam logic [2:0] RES_ONE = 3'h1;
  localparam logic [2:0] RES_TWO = 3'h2;
  localparam logic [2:0] RES_DATA = 3'h7;
  localparam int RES_BYTES = 7;

  // Flag positions in the command bytes
  localparam int BIT_MULTI = 7;
  localparam int BIT_DENS = 6;
  localparam int BIT_SKIP = 5;
  localparam int BIT_HEAD = 2;
  localparam int BIT_NO_DMA = 0;

  // Main status register bit positions
  localparam int MSR_RQM = 7;
  localparam int MSR_DIO = 6;
  localparam int MSR_EXM = 5;
  localparam int MSR_BUSY = 4;

  // Status byte values
  localparam logic [7:0] ST0_SEEK_END = 8'h20;
  localparam logic [7:0] ST0_EQUIP_FAIL = 8'h70;
  localparam logic [7:0] ST0_INVALID = 8'h80;

  // Timing scales in milliseconds, recalibrate step limit, base sector length in bytes
  localparam logic [4:0] STEP_MS_BASE = 5'h10;
  localparam logic [7:0] SETTLE_MS_UNIT = 8'h02;
  localparam logic [7:0] RELEASE_MS_UNIT = 8'h10;
  localparam logic [7:0] RECAL_MAX_STEPS = 8'hff;
  localparam logic [15:0] SECTOR_BASE_LEN = 16'h0080;

  // Reset values
  localparam logic [3:0] STEP_INTERVAL_RST = 4'h0;
  localparam logic [3:0] RELEASE_DELAY_RST = 4'h0;
  localparam logic [6:0] SETTLE_TIME_RST = 7'h01;
  localparam logic NO_DMA_RST = 1'b0;
  localparam logic [7:0] CYL_RST = 8'h00;

  typedef enum logic [2:0] {
    PH_CMD = 3'b001,
    PH_EXEC = 3'b010,
    PH_RESULT = 3'b100
  } fpcd_phase_type;

  typedef enum logic [3:0] {
    HD_OFF = 4'b0001,
    HD_SETTLE = 4'b0010,
    HD_ON = 4'b0100,
    HD_RELEASE = 4'b1000
  } fpcd_head_type;

  // Per drive condition, laid out as the top bits of the drive status
  typedef struct packed {
    logic fault;
    logic write_protect;
    logic ready;
    logic track_zero;
    logic two_sided;
  } fpcd_drive_type;

  typedef struct packed {
    logic [7:0] cmd_status_zero;
    logic [7:0] cmd_status_one;
    logic [7:0] cmd_status_two;
    logic [7:0] cyl;
    logic [7:0] head_id;
    logic [7:0] sector;
    logic [7:0] size_code;
  } fpcd_result_type;

  typedef struct packed {
    logic [4:0] op;
    logic multi_side;
    logic double_density;
    logic skip_deleted;
    logic head_pick;
    logic [1:0] drive;
    logic [7:0] cyl;
    logic [7:0] head_id;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] last_sector_number;
    logic [7:0] gap_three_length;
    logic [7:0] short_sector_length;
    logic [7:0] scan_stride;
    logic [7:0] sectors_per_cylinder;
    logic [7:0] fill_byte;
    logic [15:0] xfer_len;
  } fpcd_xfer_type;

endpackage

// File: sim/fpcd_asserts.sv
// Assertion checker for the positioning command decoder
`timescale 1ns/1ns
module fpcd_asserts
  import fpcd_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic host_wr,
  input wire logic no_dma_flag,
  input wire logic int_req,
  input wire logic [3:0] drive_sel,
  input wire logic head_pick,
  input wire logic step_pulse,
  input wire logic xfer_start
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  logic [15:0] since;
  always_ff @(posedge clock) begin
    since <= (srst || step_pulse) ? 16'h0000 : (since == 16'hffff) ? since : since + 16'h0001;
  end
  sequence quiet_step;
    !step_pulse [*3];
  endsequence
  chk_step_single: assert property (step_pulse |=> quiet_step)
    else $error("step pulse repeated too soon");
  chk_step_spacing: assert property (step_pulse |-> since >= MS_CYCLES_P - 1)
    else $error("step interval too short");
  chk_xfer_single: assert property (xfer_start |=> !xfer_start)
    else $error("transfer start longer than one cycle");
  chk_drive_onehot: assert property ($onehot(drive_sel))
    else $error("drive select not one-hot");
  chk_int_clear: assert property (!$past(srst) && $fell(int_req) |-> $past(host_wr))
    else $error("interrupt dropped without a write");
  chk_nodma_write: assert property ($changed(no_dma_flag) && !$past(srst) |-> $past(host_wr))
    else $error("no-DMA flag changed without a write");
  chk_head_write: assert property ($changed(head_pick) && !$past(srst) |-> $past(host_wr))
    else $error("head select changed without a write");
  chk_drive_write: assert property ($changed(drive_sel) && !$past(srst) |-> $past(host_wr))
    else $error("drive select changed without a write");
endmodule
bind fpcd_decoder fpcd_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (.clock(clock), .srst(srst),
  .host_wr(host_wr), .no_dma_flag(no_dma_flag), .int_req(int_req), .drive_sel(drive_sel),
  .head_pick(head_pick), .step_pulse(step_pulse), .xfer_start(xfer_start));

// File: sim/fpcd_drive_model.sv
// Model of the drives and the data sequencer facing the decoder
`timescale 1ns/1ns
module fpcd_drive_model
  import fpcd_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] drive_sel,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic xfer_start,
  input wire fpcd_result_type res_in,
  input wire logic [3:0] delay,
  output fpcd_drive_type [3:0] drive_in,
  output logic xfer_done,
  output fpcd_result_type xfer_result
);
  logic [3:0][7:0] cyl;
  logic [3:0] wait_n;
  logic busy;
  always_ff @(posedge clock) begin
    if (srst) begin
      cyl <= {4{8'h03}};
      busy <= 1'b0;
      xfer_done <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (step_pulse && drive_sel[i]) begin
          cyl[i] <= step_dir ? cyl[i] + 8'h01 : cyl[i] - 8'h01;
        end
      end
      xfer_done <= 1'b0;
      if (xfer_start) begin
        busy <= 1'b1;
        wait_n <= delay;
      end else if (busy && wait_n == 4'h0) begin
        busy <= 1'b0;
        xfer_done <= 1'b1;
      end else begin
        wait_n <= wait_n - 4'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      drive_in[i] = {1'b0, i[0], 1'b1, cyl[i] == 8'h00, 1'b1};
    end
    xfer_result = xfer_done ? res_in : ~res_in;
  end
endmodule

// File: sim/test_fpcd_decoder.sv
// Self-checking bench for the positioning command decoder
`timescale 1ns/1ns
module test_fpcd_decoder;
  import fpcd_pkg::*;
  logic clock, srst, reg_select_line, host_wr, host_rd, int_req, no_dma_flag;
  logic head_pick, head_load, step_pulse, step_dir, xfer_start, xfer_done;
  logic [7:0] host_wdata, host_rdata;
  logic [3:0] drive_sel, delay;
  fpcd_drive_type [3:0] drive_in;
  fpcd_xfer_type xfer;
  fpcd_result_type xfer_result, res_in;
  logic [31:0] seed = 32'h0001636e;
  int miscompares = 0, n_checks = 0, cyc = 0, steps = 0, t_last = 0, t_prev = 0;
  fpcd_decoder #(.MS_CYCLES_P(4)) u_dut (.clock, .srst, .reg_select_line, .host_wr, .host_rd,
    .host_wdata, .host_rdata, .int_req, .no_dma_flag, .drive_in, .drive_sel, .head_pick,
    .head_load, .step_pulse, .step_dir, .xfer_start, .xfer, .xfer_done, .xfer_result);
  fpcd_drive_model u_model (.clock, .srst, .drive_sel, .step_pulse, .step_dir, .xfer_start,
    .res_in, .delay, .drive_in, .xfer_done, .xfer_result);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] b);
    @(negedge clock);
    reg_select_line = 1'b1;
    host_wr = 1'b1;
    host_wdata = b;
    @(negedge clock);
    host_wr = 1'b0;
  endtask
  task automatic rd(input logic sel_in, output logic [7:0] v);
    @(negedge clock);
    reg_select_line = sel_in;
    host_rd = sel_in;
    @(negedge clock);
    host_rd = 1'b0;
    v = host_rdata;
  endtask
  task automatic wait_int();
    for (int m = 0; m < 2200 && int_req !== 1'b1; m++)
      @(negedge clock);
  endtask
  task automatic sense_int(input logic [7:0] st, input logic [7:0] c);
    logic [7:0] v;
    wr(8'h08);
    rd(1'b1, v);
    check("sense status", v, st);
    rd(1'b1, v);
    check("present cylinder", v, c);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (step_pulse) begin
      steps++;
      t_prev = t_last;
      t_last = cyc;
    end
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    logic [7:0] v, t;
    logic [1:0] d;
    logic h;
    logic [7:0] p [9];
    srst = 1'b1;
    reg_select_line = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
    res_in = '0;
    delay = 4'h2;
    repeat (3) @(negedge clock);
    srst = 1'b0;
    rd(1'b0, v);
    check("main status", v, 8'h80);
    check("drive select", drive_sel, 4'h1);
    wr(8'h03);
    wr(8'he5);
    wr(8'h05);
    check("no dma", no_dma_flag, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = i[1:0];
      t = (i == 3) ? 8'hff : 8'(rnd() % 32'h5 + 32'h1);
      steps = 0;
      wr(8'h07);
      wr({6'h00, d});
      wait_int();
      check("recal steps", 16'(steps), 16'h0003);
      check("step gap", 16'(t_last - t_prev), 16'h0008);
      check("drive select", drive_sel, 4'h1 << d);
      sense_int(8'h20 | d, 8'h00);
      steps = 0;
      wr(8'h0f);
      wr({6'h00, d});
      wr(t);
      wait_int();
      check("seek steps", 16'(steps), {8'h00, t});
      check("step dir", step_dir, 1'b1);
      sense_int(8'h20 | d, t);
      h = 1'(rnd());
      wr(8'h04);
      wr({5'h00, h, d});
      rd(1'b1, v);
      check("drive status", v, {1'b0, d[0], 1'b1, 1'b0, 1'b1, h, d});
      check("head pick", head_pick, h);
    end
    sense_int(8'h80, 8'h00);
    for (int k = 0; k < 2; k++) begin
      v = 8'(rnd());
      p[0] = {v[7:5], OP_READ};
      p[1] = {5'h00, v[2:0]};
      for (int j = 2; j < 9; j++)
        p[j] = 8'(rnd());
      p[5] = 8'(k * (rnd() % 32'h3 + 32'h1));
      res_in = 56'({rnd(), rnd()});
      delay = 4'(rnd());
      for (int j = 0; j < 9; j++)
        wr(p[j]);
      for (int m = 0; m < 200 && xfer_start !== 1'b1; m++)
        @(negedge clock);
      check("multi side", xfer.multi_side, p[0][7]);
      check("density", xfer.double_density, p[0][6]);
      check("skip", xfer.skip_deleted, p[0][5]);
      check("last sector", xfer.last_sector_number, p[6]);
      check("cylinder", xfer.cyl, p[2]);
      check("gap three", xfer.gap_three_length, p[7]);
      check("head load", head_load, 1'b1);
      check("length", xfer.xfer_len, p[5] == 8'h00 ? {8'h00, p[8]} : 16'h0080 << p[5][2:0]);
      v = 8'h00;
      for (int m = 0; m < 50 && v[6] !== 1'b1; m++)
        rd(1'b0, v);
      for (int j = 0; j < 7; j++) begin
        rd(1'b1, v);
        check("result byte", v, res_in[55 - 8 * j -: 8]);
      end
    end
    report_and_stop();
  end
endmodule
